/* inc/frame_sync_map.vh */
// Notes on behaviour
// - Source-select 0 takes 2k/8k syncs from primary DPLL, 1 from secondary.
// - Frame-sync invert bit set inverts the 8 kHz frame-sync output.
// - Frame-sync pulse bit gives a one reference-period pulse; software keeps reference enabled.
// - Multiframe-sync invert bit set inverts the 2 kHz multiframe-sync output.
// - Multiframe pulse bit gives one reference-period pulse; software keeps reference enabled.
// - Independent bit 0 aligns all clocks on external sync; 1 realigns only syncs.
// - High-rate bit 0 samples external sync at 6.48 MHz resolution.
// - High-rate bit 1 samples external sync at the selected reference rate.
// - Two-bit phase field shifts the external sync sampling point.
// - Writing recalibrate 1 runs holdover, ramp to zero, divider reset, ramp back, leave.
// - Recalibrate bit clears itself when the sequence finishes.
// - Monitor alarm sets when external sync misaligns by code plus one cycles.
// - Auto sync accepts input only while primary DPLL locks to chosen source 1..14.
// - Output bit set turns the interrupt pin into a general-purpose output.
// - Interrupt use: open-drain 0 drives both states, 1 drives only active.
// - Output use: open-drain 1 floats pin, else pin follows polarity bit.
// - Interrupt use: polarity 0 signals low, polarity 1 signals high.
// - Output use with pin driven: pin level equals polarity bit.
// - Code 85h allows all writes; non-unlock codes block writes except protection.
// - Code 86h allows one other write, then protection becomes 00h.
// - Interface-select pins latch at reset; later changes show only in pin status.
// - Latched code selects parallel style, multiplexing, or SPI bit order.
`ifndef FRAME_SYNC_MAP_VH
`define FRAME_SYNC_MAP_VH
`define ADDR_FS_OUT 8'h7A
`define ADDR_FS_ALIGN 8'h7B
`define ADDR_MON_PHASE_OFFSET_RECALIBRATE 8'h7C
`define ADDR_IRQ_PIN 8'h7D
`define ADDR_PROTECT 8'h7E
`define ADDR_IF_SEL 8'h7F
`define MASK_FS_OUT 8'h8F
`define MASK_FS_ALIGN 8'hC3
`define MASK_MON_PHASE_OFFSET_RECALIBRATE 8'hFF
`define MASK_IRQ_PIN 8'h07
`define RST_FS_OUT 8'h00
`define RST_FS_ALIGN 8'h00
`define RST_MON_PHASE_OFFSET_RECALIBRATE 8'h2B
`define RST_IRQ_PIN 8'h00
`define RST_PROTECT 8'h85
`define WRITE_PROTECTION_FULL 8'h85
`define WRITE_PROTECTION_SINGLE 8'h86
`define WRITE_PROTECTION_LOCKED 8'h00
`define BIT_SRC_SEL 7
`define BIT_FS_INV 3
`define BIT_FS_PUL 2
`define BIT_MF_INV 1
`define BIT_MF_PUL 0
`define BIT_INDEPENDENT_SYNC_ALIGN 7
`define BIT_HIGH_RATE 6
`define BIT_PHASE_OFFSET_RECALIBRATE 7
`define BIT_GPO 2
`define BIT_OD 1
`define BIT_POL 0
`define SRC_FIRST 4'h1
`define SRC_LAST 4'hE
`define RAMP_STEPS 8'h10
`endif

/* rtl/frame_sync_irq_protect_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_map.vh"
module frame_sync_irq_protect_regs
(
  input wire clock_in,
  input wire sys_rst_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  output reg [7:0] rd_data_out,
  output wire write_allowed_out,
  input wire [2:0] host_interface_mode_pins_in,
  output reg [2:0] interface_pin_status_out,
  output wire [2:0] host_interface_mode_out,
  output wire bus_parallel_out,
  output wire bus_alt_style_out,
  output wire bus_multiplexed_out,
  output wire bus_spi_out,
  output wire spi_msb_first_out,
  input wire primary_frame_sync_in,
  input wire primary_multiframe_sync_in,
  input wire secondary_frame_sync_in,
  input wire secondary_multiframe_sync_in,
  input wire reference_tick_in,
  input wire sampling_tick_in,
  input wire external_sync_input_in,
  output reg frame_sync_output_out,
  output reg multiframe_sync_output_out,
  output reg gen_frame_sync_out,
  output reg gen_multiframe_sync_out,
  output wire independent_sync_align_out,
  output wire high_rate_sync_sampling_out,
  output wire [1:0] sync_sample_phase_out,
  output reg sync_align_strobe_out,
  input wire auto_external_sync_enable_in,
  input wire primary_dpll_locked_in,
  input wire [3:0] primary_dpll_input_in,
  output reg frame_sync_monitor_alarm_out,
  output reg mini_holdover_out,
  output reg offset_ramp_zero_out,
  output reg divider_reset_out,
  output reg offset_ramp_restore_out,
  input wire offset_ramp_done_in,
  input wire irq_active_in,
  output reg interrupt_request_pin_out,
  output reg interrupt_request_pin_oe_out
);

////////////////////////////////////////////////////////////////////////////////
reg [7:0] fs_out_q;
reg [7:0] fs_align_q;
reg [7:0] mon_phase_offset_recalibrate_q;
reg [7:0] irq_pin_q;
reg [7:0] protect_q;
reg [2:0] if_sel_q;
reg [2:0] pins_meta_q;
reg [2:0] pins_sync_q;
reg ext_meta_q;
reg ext_sync_q;
reg ext_prev_q;
reg phase_offset_recalibrate_done_q;
reg [4:0] phase_offset_recalibrate_state_q;
reg [4:0] phase_offset_recalibrate_state_d;
reg [7:0] mon_cnt_q;
reg mf_prev_q;
reg fs_raw_prev_q;
reg mf_raw_prev_q;
reg fs_pulse_q;
reg mf_pulse_q;

localparam [4:0] RC_IDLE = 5'h01;
localparam [4:0] RC_HOLD = 5'h02;
localparam [4:0] RC_ZERO = 5'h04;
localparam [4:0] RC_DIV = 5'h08;
localparam [4:0] RC_BACK = 5'h10;

function [7:0] masked_read;
  input [7:0] value;
  input [7:0] mask;
  begin
    masked_read = value & mask;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Write protection gate.
wire write_protection_full = (protect_q == `WRITE_PROTECTION_FULL);
wire write_protection_single = (protect_q == `WRITE_PROTECTION_SINGLE);
wire other_addr = (addr_in >= `ADDR_FS_OUT) && (addr_in <= `ADDR_IRQ_PIN);
assign write_allowed_out = write_protection_full | write_protection_single;
wire wr_other = wr_en_in & write_allowed_out & other_addr;
wire wr_write_protection = wr_en_in & (addr_in == `ADDR_PROTECT);
wire phase_offset_recalibrate_start = wr_other && (addr_in == `ADDR_MON_PHASE_OFFSET_RECALIBRATE) && wr_data_in[`BIT_PHASE_OFFSET_RECALIBRATE];

always @(posedge clock_in)
begin
  if (sys_rst_in)
  begin
    protect_q <= `RST_PROTECT;
  end
  else if (wr_write_protection)
  begin
    protect_q <= wr_data_in;
  end
  else if (wr_en_in && write_protection_single && other_addr)
  begin
    protect_q <= `WRITE_PROTECTION_LOCKED;
  end
end

always @(posedge clock_in)
begin
  if (sys_rst_in)
  begin
    fs_out_q <= `RST_FS_OUT;
    fs_align_q <= `RST_FS_ALIGN;
    irq_pin_q <= `RST_IRQ_PIN;
  end
  else if (wr_other)
  begin
    if (addr_in == `ADDR_FS_OUT)
      fs_out_q <= wr_data_in & `MASK_FS_OUT;
    if (addr_in == `ADDR_FS_ALIGN)
      fs_align_q <= wr_data_in & `MASK_FS_ALIGN;
    if (addr_in == `ADDR_IRQ_PIN)
      irq_pin_q <= wr_data_in & `MASK_IRQ_PIN;
  end
end

// The recalibrate bit is held by the sequencer; a register write wins over the completion clear.
always @(posedge clock_in)
begin
  if (sys_rst_in)
  begin
    mon_phase_offset_recalibrate_q <= `RST_MON_PHASE_OFFSET_RECALIBRATE;
  end
  else
  begin
    if (wr_other && (addr_in == `ADDR_MON_PHASE_OFFSET_RECALIBRATE))
      mon_phase_offset_recalibrate_q <= wr_data_in | {phase_offset_recalibrate_state_q != RC_IDLE, 7'h00};
    else if (phase_offset_recalibrate_done_q)
      mon_phase_offset_recalibrate_q[`BIT_PHASE_OFFSET_RECALIBRATE] <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interface-select strap: captured while reset is held, clocked, never async.
always @(posedge clock_in)
begin
  pins_meta_q <= host_interface_mode_pins_in;
  pins_sync_q <= pins_meta_q;
  interface_pin_status_out <= pins_sync_q;
  if (sys_rst_in)
    if_sel_q <= pins_sync_q;
end

assign host_interface_mode_out = if_sel_q;
// Codes 000 and 001 select nothing; all decoded outputs then stay low.
assign bus_parallel_out = (if_sel_q[2:1] == 2'b01) || (if_sel_q == 3'b110)
  || (if_sel_q == 3'b100);
assign bus_alt_style_out = (if_sel_q == 3'b110) || (if_sel_q == 3'b100);
assign bus_multiplexed_out = (if_sel_q == 3'b010) || (if_sel_q == 3'b110);
assign bus_spi_out = (if_sel_q == 3'b101) || (if_sel_q == 3'b111);
assign spi_msb_first_out = (if_sel_q == 3'b111);

////////////////////////////////////////////////////////////////////////////////
// Read mux.
always @(posedge clock_in)
begin
  if (sys_rst_in)
    rd_data_out <= 8'h00;
  else if (rd_en_in)
  begin
    case (addr_in)
      `ADDR_FS_OUT: rd_data_out <= masked_read(fs_out_q, `MASK_FS_OUT);
      `ADDR_FS_ALIGN: rd_data_out <= masked_read(fs_align_q, `MASK_FS_ALIGN);
      `ADDR_MON_PHASE_OFFSET_RECALIBRATE: rd_data_out <= masked_read(mon_phase_offset_recalibrate_q, `MASK_MON_PHASE_OFFSET_RECALIBRATE);
      `ADDR_IRQ_PIN: rd_data_out <= masked_read(irq_pin_q, `MASK_IRQ_PIN);
      `ADDR_PROTECT: rd_data_out <= protect_q;
      `ADDR_IF_SEL: rd_data_out <= {5'h00, if_sel_q};
      default: rd_data_out <= 8'h00;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sync outputs. The general outputs take the chosen DPLL's raw syncs.
wire src_sec = fs_out_q[`BIT_SRC_SEL];
wire fs_raw = src_sec ? secondary_frame_sync_in : primary_frame_sync_in;
wire mf_raw = src_sec ? secondary_multiframe_sync_in : primary_multiframe_sync_in;

// Pulse mode starts on the raw rising edge and lasts one reference tick;
// with the reference stopped the pulse would never end, hence the software duty.
always @(posedge clock_in)
begin
  if (sys_rst_in)
  begin
    fs_raw_prev_q <= 1'b0;
    mf_raw_prev_q <= 1'b0;
    fs_pulse_q <= 1'b0;
    mf_pulse_q <= 1'b0;
    gen_frame_sync_out <= 1'b0;
    gen_multiframe_sync_out <= 1'b0;
    frame_sync_output_out <= 1'b0;
    multiframe_sync_output_out <= 1'b0;
  end
  else
  begin
    fs_raw_prev_q <= fs_raw;
    mf_raw_prev_q <= mf_raw;
    gen_frame_sync_out <= fs_raw;
    gen_multiframe_sync_out <= mf_raw;
    if (fs_raw && !fs_raw_prev_q)
      fs_pulse_q <= 1'b1;
    else if (reference_tick_in)
      fs_pulse_q <= 1'b0;
    if (mf_raw && !mf_raw_prev_q)
      mf_pulse_q <= 1'b1;
    else if (reference_tick_in)
      mf_pulse_q <= 1'b0;
    frame_sync_output_out <= (fs_out_q[`BIT_FS_PUL] ? fs_pulse_q : fs_raw)
      ^ fs_out_q[`BIT_FS_INV];
    multiframe_sync_output_out <= (fs_out_q[`BIT_MF_PUL] ? mf_pulse_q : mf_raw)
      ^ fs_out_q[`BIT_MF_INV];
  end
end

////////////////////////////////////////////////////////////////////////////////
// External sync sampling and monitor. The sampling tick comes from the
// reference divider at 6.48 MHz or at the reference rate; phase is passed on.
assign independent_sync_align_out = fs_align_q[`BIT_INDEPENDENT_SYNC_ALIGN];
assign high_rate_sync_sampling_out = fs_align_q[`BIT_HIGH_RATE];
assign sync_sample_phase_out = fs_align_q[1:0];

wire src_valid = (mon_phase_offset_recalibrate_q[3:0] >= `SRC_FIRST) && (mon_phase_offset_recalibrate_q[3:0] <= `SRC_LAST);
wire ext_accept = !auto_external_sync_enable_in || (primary_dpll_locked_in
  && src_valid && (primary_dpll_input_in == mon_phase_offset_recalibrate_q[3:0]));
wire [7:0] mon_limit = {5'h00, mon_phase_offset_recalibrate_q[6:4]} + 8'h01;

always @(posedge clock_in)
begin
  ext_meta_q <= external_sync_input_in;
  ext_sync_q <= ext_meta_q;
  if (sys_rst_in)
  begin
    ext_prev_q <= 1'b0;
    mf_prev_q <= 1'b0;
    mon_cnt_q <= 8'h00;
    sync_align_strobe_out <= 1'b0;
    frame_sync_monitor_alarm_out <= 1'b0;
  end
  else
  begin
    sync_align_strobe_out <= 1'b0;
    if (sampling_tick_in)
    begin
      ext_prev_q <= ext_sync_q;
      mf_prev_q <= mf_raw;
      if (mf_raw && !mf_prev_q)
        mon_cnt_q <= 8'h00;
      else if (mon_cnt_q != 8'hFF)
        mon_cnt_q <= mon_cnt_q + 8'h01;
      if (ext_accept && !ext_sync_q && ext_prev_q)
      begin
        sync_align_strobe_out <= 1'b1;
        // Distance since the last multiframe edge, in sampling ticks, saturating at FFh.
        frame_sync_monitor_alarm_out <= (mon_cnt_q >= mon_limit);
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Recalibration sequencer.
always @*
begin
  phase_offset_recalibrate_state_d = phase_offset_recalibrate_state_q;
  case (phase_offset_recalibrate_state_q)
    RC_IDLE: if (phase_offset_recalibrate_start) phase_offset_recalibrate_state_d = RC_HOLD;
    RC_HOLD: phase_offset_recalibrate_state_d = RC_ZERO;
    RC_ZERO: if (offset_ramp_done_in) phase_offset_recalibrate_state_d = RC_DIV;
    RC_DIV: phase_offset_recalibrate_state_d = RC_BACK;
    RC_BACK: if (offset_ramp_done_in) phase_offset_recalibrate_state_d = RC_IDLE;
    default: phase_offset_recalibrate_state_d = RC_IDLE;
  endcase
end

always @(posedge clock_in)
begin
  if (sys_rst_in)
  begin
    phase_offset_recalibrate_state_q <= RC_IDLE;
    phase_offset_recalibrate_done_q <= 1'b0;
    mini_holdover_out <= 1'b0;
    offset_ramp_zero_out <= 1'b0;
    divider_reset_out <= 1'b0;
    offset_ramp_restore_out <= 1'b0;
  end
  else
  begin
    phase_offset_recalibrate_state_q <= phase_offset_recalibrate_state_d;
    phase_offset_recalibrate_done_q <= (phase_offset_recalibrate_state_q == RC_BACK) && (phase_offset_recalibrate_state_d == RC_IDLE);
    mini_holdover_out <= (phase_offset_recalibrate_state_d != RC_IDLE);
    offset_ramp_zero_out <= (phase_offset_recalibrate_state_d == RC_ZERO);
    divider_reset_out <= (phase_offset_recalibrate_state_d == RC_DIV);
    offset_ramp_restore_out <= (phase_offset_recalibrate_state_d == RC_BACK);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt pin drive.
wire irq_pin_as_output = irq_pin_q[`BIT_GPO];
wire od = irq_pin_q[`BIT_OD];
wire irq_pin_polarity = irq_pin_q[`BIT_POL];

always @(posedge clock_in)
begin
  if (sys_rst_in)
  begin
    interrupt_request_pin_out <= 1'b1;
    interrupt_request_pin_oe_out <= 1'b1;
  end
  else if (irq_pin_as_output)
  begin
    interrupt_request_pin_out <= irq_pin_polarity;
    interrupt_request_pin_oe_out <= !od;
  end
  else
  begin
    interrupt_request_pin_out <= irq_active_in ? irq_pin_polarity : !irq_pin_polarity;
    interrupt_request_pin_oe_out <= !od || irq_active_in;
  end
end

endmodule
`default_nettype wire

/* testbench/fs_regs_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module fs_regs_checker
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_data_out,
  input wire logic write_allowed_out,
  input wire logic [2:0] host_interface_mode_out,
  input wire logic bus_parallel_out,
  input wire logic bus_multiplexed_out,
  input wire logic bus_spi_out,
  input wire logic spi_msb_first_out,
  input wire logic sync_align_strobe_out,
  input wire logic mini_holdover_out,
  input wire logic divider_reset_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire [2:0] m = host_interface_mode_out;
  ////////////////////////////////////////////////////////////////////////////////
  a_unmapped_zero:
    assert property (rd_en_in && !(addr_in inside {[8'h7A:8'h7F]}) |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_mode_readback:
    assert property (rd_en_in && addr_in == 8'h7F |=> rd_data_out == {5'h00, m})
    else $error("mode register read wrong");
  a_mode_held:
    assert property (!$past(sys_rst_in) |-> $stable(host_interface_mode_out))
    else $error("latched mode moved after reset");
  a_spi_decode:
    assert property (bus_spi_out == (m[2] & m[0]) && spi_msb_first_out == (m == 3'h7))
    else $error("serial mode decode wrong");
  a_bus_decode:
    assert property (bus_parallel_out == (m inside {3'h2, 3'h3, 3'h4, 3'h6})
      && bus_multiplexed_out == (m inside {3'h2, 3'h6})) else $error("bus decode wrong");
  a_write_gate:
    assert property (wr_en_in && addr_in == 8'h7E |=>
      write_allowed_out == ($past(wr_data_in) inside {8'h85, 8'h86})) else $error("gate wrong");
  a_div_pulse:
    assert property ($rose(divider_reset_out) |=> !divider_reset_out)
    else $error("divider reset longer than one cycle");
  a_div_in_holdover:
    assert property (divider_reset_out |-> mini_holdover_out)
    else $error("divider reset outside holdover");
  a_phase_offset_recalibrate_start:
    assert property (wr_en_in && write_allowed_out && addr_in == 8'h7C && wr_data_in[7]
      && !mini_holdover_out |=> mini_holdover_out) else $error("recalibration did not start");
  a_strobe_single:
    assert property (sync_align_strobe_out |=> !sync_align_strobe_out)
    else $error("align strobe longer than one cycle");
endmodule
`default_nettype wire

/* testbench/ramp_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Answers each ramp request once after DELAY cycles; the count keeps running so a
// request that stays high a cycle too long never gets a second done.
module ramp_partner #(parameter int DELAY = 5)
(
  input wire logic clock_in,
  input wire logic ramp_req_in,
  output logic done_out
);
  int cnt = 0;
  initial done_out = 1'b0;
  always @(posedge clock_in)
  begin
    done_out <= ramp_req_in && cnt == DELAY;
    cnt <= ramp_req_in ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

/* testbench/tb_frame_sync_irq_protect_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_map.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_frame_sync_irq_protect_regs;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out, v, d;
  logic [2:0] host_interface_mode_pins_in = 3'h0, interface_pin_status_out;
  logic [2:0] host_interface_mode_out, pins;
  logic [3:0] syn = 4'h0, primary_dpll_input_in = 4'h0;
  logic [1:0] sync_sample_phase_out;
  logic reference_tick_in = 1'b0, sampling_tick_in = 1'b0, external_sync_input_in = 1'b1;
  logic auto_external_sync_enable_in = 1'b0, primary_dpll_locked_in = 1'b0;
  logic irq_active_in = 1'b0, offset_ramp_done_in, seen = 1'b0, got, tick_all = 1'b0;
  logic write_allowed_out, bus_parallel_out, bus_alt_style_out, bus_multiplexed_out;
  logic bus_spi_out, spi_msb_first_out, frame_sync_output_out, multiframe_sync_output_out;
  logic gen_frame_sync_out, gen_multiframe_sync_out, independent_sync_align_out;
  logic high_rate_sync_sampling_out, sync_align_strobe_out, frame_sync_monitor_alarm_out;
  logic mini_holdover_out, offset_ramp_zero_out, divider_reset_out, offset_ramp_restore_out;
  logic interrupt_request_pin_out, interrupt_request_pin_oe_out;
  int n_errors = 0, num_checks = 0;
  logic [7:0] rst_tab [0:4] = '{8'h00, 8'h00, 8'h2B, 8'h00, 8'h85};
  logic [7:0] msk [0:3] = '{`MASK_FS_OUT, `MASK_FS_ALIGN, `MASK_MON_PHASE_OFFSET_RECALIBRATE, `MASK_IRQ_PIN};
  logic [6:0] cs [0:3] = '{7'h01, 7'h56, 7'h77, 7'h74};
  wire primary_frame_sync_in = syn[3];
  wire primary_multiframe_sync_in = syn[2];
  wire secondary_frame_sync_in = syn[1];
  wire secondary_multiframe_sync_in = syn[0];
  wire [1:0] sync_pair = {frame_sync_output_out, multiframe_sync_output_out};
  wire [3:0] align_bits = {independent_sync_align_out, high_rate_sync_sampling_out,
    sync_sample_phase_out};
  wire [7:0] mode_bits = {host_interface_mode_out, bus_parallel_out, bus_alt_style_out,
    bus_multiplexed_out, bus_spi_out, spi_msb_first_out};
  frame_sync_irq_protect_regs dut (.*);
  ramp_partner #(.DELAY(5)) ramp (.clock_in(clock_in),
    .ramp_req_in(offset_ramp_zero_out | offset_ramp_restore_out), .done_out(offset_ramp_done_in));
  always #10 clock_in = ~clock_in;
  // Random ticks by default; the monitor test forces one every cycle so counts are exact.
  always @(posedge clock_in) sampling_tick_in <= #1 tick_all | 1'($urandom);
  always @(posedge clock_in) if (divider_reset_out === 1'b1) seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    addr_in = a;
    wr_data_in = x;
    wr_en_in = 1'b1;
    tick();
    wr_en_in = 1'b0;
    tick();
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] r);
    addr_in = a;
    rd_en_in = 1'b1;
    tick();
    rd_en_in = 1'b0;
    r = rd_data_out;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    rdv(a, r);
    `CHK(r, e)
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Pin expectation: interrupt use drives the active level always and the idle one
  // only when not open-drain; output use drives the polarity level unless open-drain.
  function automatic logic [1:0] irq_exp(input logic [2:0] c, input logic act);
    logic oe;
    oe = c[2] ? !c[1] : (act || !c[1]);
    return {oe, oe & (c[2] ? c[0] : (act ? c[0] : !c[0]))};
  endfunction
  // Decoded interface flags: parallel, alternate style, multiplexed, serial, serial MSB first.
  function automatic logic [4:0] mode_exp(input logic [2:0] c);
    return {c inside {3'h2, 3'h3, 3'h4, 3'h6}, c inside {3'h4, 3'h6}, c inside {3'h2, 3'h6},
      c inside {3'h5, 3'h7}, c == 3'h7};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    v = 8'($urandom(32'h532B7648));
    pins = 3'($urandom);
    host_interface_mode_pins_in = pins;
    tick(16);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 5; i++) rd(8'h7A + 8'(i), rst_tab[i]);
    rd(`ADDR_IF_SEL, {5'h00, pins});
    `CHK(mode_bits, {pins, mode_exp(pins)})
    host_interface_mode_pins_in = ~pins;
    wr(`ADDR_IF_SEL, 8'hFF);
    tick(5);
    `CHK(interface_pin_status_out, ~pins)
    rd(`ADDR_IF_SEL, {5'h00, pins});
    `CHK(mode_bits, {pins, mode_exp(pins)})
    rd(8'h79, 8'h00);
    rd(8'h80, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom) & (i % 4 == 2 ? 8'h7F : 8'hFF);
      wr(8'h7A + 8'(i % 4), d);
      rd(8'h7A + 8'(i % 4), d & msk[i % 4]);
      if (i % 4 == 1) `CHK(align_bits, {d[7:6], d[1:0]})
    end
    $display("test registers done");
    wr(`ADDR_FS_OUT, 8'h00);
    wr(`ADDR_PROTECT, 8'h87);
    wr(`ADDR_FS_OUT, 8'h8F);
    rd(`ADDR_FS_OUT, 8'h00);
    wr(`ADDR_PROTECT, `WRITE_PROTECTION_SINGLE);
    rd(`ADDR_PROTECT, `WRITE_PROTECTION_SINGLE);
    wr(`ADDR_FS_OUT, 8'h8F);
    rd(`ADDR_PROTECT, `WRITE_PROTECTION_LOCKED);
    wr(`ADDR_FS_OUT, 8'h00);
    rd(`ADDR_FS_OUT, 8'h8F);
    wr(`ADDR_PROTECT, `WRITE_PROTECTION_FULL);
    $display("test protection done");
    for (int i = 0; i < 12; i++)
    begin
      d = 8'($urandom) & 8'h8A;
      syn = 4'($urandom);
      wr(`ADDR_FS_OUT, d);
      tick(3);
      v[1:0] = d[7] ? syn[1:0] : syn[3:2];
      `CHK({gen_frame_sync_out, gen_multiframe_sync_out}, v[1:0])
      `CHK(sync_pair, v[1:0] ^ {d[3], d[1]})
    end
    syn = 4'h0;
    wr(`ADDR_FS_OUT, 8'h05);
    tick(3);
    syn = 4'hC;
    tick(4);
    `CHK(sync_pair, 2'b11)
    reference_tick_in = 1'b1;
    tick();
    reference_tick_in = 1'b0;
    tick(3);
    `CHK(sync_pair, 2'b00)
    $display("test sync outputs done");
    for (int i = 0; i < 16; i++)
    begin
      wr(`ADDR_IRQ_PIN, {5'h00, 3'(i)});
      irq_active_in = i[3];
      tick(2);
      `CHK({interrupt_request_pin_oe_out, interrupt_request_pin_oe_out &
        interrupt_request_pin_out}, irq_exp(3'(i), i[3]))
    end
    $display("test interrupt pin done");
    wr(`ADDR_MON_PHASE_OFFSET_RECALIBRATE, 8'hAB);
    v = 8'hFF;
    for (int n = 0; n < 60 && v[7] !== 1'b0; n++) rdv(`ADDR_MON_PHASE_OFFSET_RECALIBRATE, v);
    if (v[7] !== 1'b0)
    begin
      n_errors++;
      wrap_up();
    end
    `CHK(v, 8'h2B)
    `CHK(seen, 1'b1)
    $display("test recalibration done");
    for (int i = 0; i < 4; i++)
    begin
      {auto_external_sync_enable_in, primary_dpll_locked_in, primary_dpll_input_in} = cs[i][6:1];
      external_sync_input_in = 1'b1;
      tick(8);
      external_sync_input_in = 1'b0;
      got = 1'b0;
      repeat (24)
      begin
        tick();
        got = got | sync_align_strobe_out;
      end
      `CHK(got, cs[i][0])
    end
    // Limit code 010 gives three ticks: an edge one tick after the multiframe edge passes,
    // one long after it raises the alarm.
    auto_external_sync_enable_in = 1'b0;
    tick_all = 1'b1;
    syn = 4'h0;
    external_sync_input_in = 1'b1;
    tick(4);
    syn = 4'hC;
    external_sync_input_in = 1'b0;
    tick(8);
    `CHK(frame_sync_monitor_alarm_out, 1'b0)
    external_sync_input_in = 1'b1;
    tick(8);
    external_sync_input_in = 1'b0;
    tick(8);
    `CHK(frame_sync_monitor_alarm_out, 1'b1)
    $display("test external sync done");
    wrap_up();
  end
endmodule
bind frame_sync_irq_protect_regs fs_regs_checker chk (.*);
`default_nettype wire
